// ### nfc_dev_model.sv
// Purpose: Behavioural model of the small-page NAND device on the pins.
// Assumes: Byte-wide part; host pins change just after mclk rises.
// Notes: Sparse memory reads erased where unwritten; fail is forced.
`timescale 1ns/1ps
module nfc_dev_model #(
	parameter int BUSY_CYC = 12
) (
	input wire logic mclk,
	input wire nfc_pkg::nfc_pins_t pins,
	input wire logic [7:0] io_out,
	input wire logic force_fail,
	output logic [7:0] io_in,
	output logic rb_low
);
	import nfc_pkg::*;
	logic [7:0] mem [int];
	logic [7:0] pbuf [528];
	logic [7:0] dout = 8'h00;
	logic [7:0] last = 8'h00;
	logic we_q = 1'b1;
	logic re_q = 1'b1;
	logic stat_m = 1'b0;
	logic failed = 1'b0;
	int mode = 0;
	int base = 0;
	int col = 0;
	int acnt = 0;
	int row = 0;
	int busy = 0;
	int k;
	function automatic logic [7:0] rdb(int a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	// Only ever pulls low; the pull-up lives outside.
	assign rb_low = busy != 0;
	// A released bus shows the inverse of its last value, never a hold.
	assign io_in = (!pins.ce_n && !pins.read_strobe_n) ? dout : ~last;
	always @(posedge mclk) begin
		last <= io_in;
		if (busy > 0) begin
			busy <= busy - 1;
			if (!pins.wp_n && mode > 3) begin
				busy <= 0;
				mode = 0;
			end else if (busy == 1 && mode == 4) begin
				for (int i = 0; i < 528; i++)
					mem[row * 528 + i] = rdb(row * 528 + i) & pbuf[i];
				failed = force_fail;
				mode = 0;
			end else if (busy == 1 && mode == 5) begin
				for (int a = row / 32 * 16896; a < (row / 32 + 1) * 16896; a++)
					mem.delete(a);
				failed = force_fail;
				mode = 0;
			end
		end
		if (pins.read_strobe_n && !re_q && !pins.ce_n && !stat_m)
			col++;
		re_q = pins.read_strobe_n;
		if (pins.we_n && !we_q && !pins.ce_n) begin
			if (pins.cle) begin
				// Anything but execute drops a loaded page unprogrammed.
				if (mode == 2 && io_out != 8'h10)
					mode = 0;
				acnt = 0;
				case (io_out)
				8'h00, 8'h01, 8'h50: begin
					base = io_out == 8'h00 ? 0 : (io_out == 8'h01 ? 256 : 512);
					stat_m = 1'b0;
					mode = 1;
				end
				8'h80: begin
					mode = 2;
					foreach (pbuf[i])
						pbuf[i] = 8'hFF;
				end
				8'h10: if (mode == 2) begin
					mode = 4;
					busy <= BUSY_CYC;
				end
				8'h60: mode = 3;
				8'hD0: if (mode == 3) begin
					mode = 5;
					busy <= BUSY_CYC;
				end
				8'h70: stat_m = 1'b1;
				8'hFF: begin
					mode = 0;
					stat_m = 1'b0;
					busy <= 0;
				end
				default: ;
				endcase
			end else if (pins.ale) begin
				k = mode != 3;
				if (k == 1 && acnt == 0)
					col = base + io_out;
				else if (acnt - k < 2)
					row[8 * (acnt - k) +: 8] = io_out;
				if (mode == 1 && acnt == 2)
					busy <= BUSY_CYC;
				acnt++;
			end else if (mode == 2 && col < 528) begin
				pbuf[col] = io_out;
				col++;
			end
		end
		we_q = pins.we_n;
		dout <= stat_m ? {pins.wp_n, busy == 0, 5'h00, failed} : rdb(row * 528 + col);
	end
endmodule

// ### nfc_fifo.sv
// Purpose: Small flip-flop FIFO for the data path.
// Assumes: Single clock.
// Notes: Ready and valid on both sides.
`timescale 1ns/1ps
module nfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	always_comb begin
		in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
		out_valid = (cnt_r != '0);
		out_data = mem_r[rp_r];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule

// ### nfc_host.sv
// Purpose: Host sequencer that drives a small-page NAND over its pins.
// Assumes: Byte-wide device, pins synchronous to mclk.
// Notes: Keeps per-block page order, partial-program count, bad table.
`include "nfc_regs.svh"
`timescale 1ns/1ps
module nfc_host (
	input wire logic mclk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire nfc_pkg::nfc_req_t req,
	output nfc_pkg::nfc_rsp_t rsp,
	output logic rsp_valid,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	input wire logic mark_bad,
	input wire logic [9:0] mark_block,
	output logic [10:0] good_blocks,
	output logic too_few_good,
	output nfc_pkg::nfc_pins_t pins,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic ready_busy_n
);
	import nfc_pkg::*;
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_DATA_W, ST_CMD2, ST_WAIT,
		ST_STAT_CMD, ST_STAT_RD, ST_DATA_R, ST_DONE
	} nfc_st_t;
	nfc_st_t st_r, st_nxt;
	nfc_req_t cur_r, cur_nxt;
	logic [7:0] io_r, io_nxt;
	logic oe_r, oe_nxt;
	nfc_pins_t pin_r, pin_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic [1:0] acnt_r, acnt_nxt;
	logic [7:0] rdat_r, rdat_nxt;
	logic rdv_r, rdv_nxt;
	nfc_rsp_t rsp_r, rsp_nxt;
	logic rspv_r, rspv_nxt;
	logic [1023:0] bad_r, bad_nxt;
	logic [10:0] good_r, good_nxt;
	logic [5:0] next_page_r [1024];
	logic [1:0] segs_r [1024];
	logic [7:0] fifo_out;
	logic fifo_v, fifo_pop;
	logic in_read_r, in_read_nxt;
	logic spare_r, spare_nxt;
	logic pg_wr, seg_wr;
	logic [5:0] pg_val;
	logic [1:0] seg_val;
	nfc_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(fifo_v),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);
	function automatic logic [7:0] first_cmd(input nfc_req_t r,
		input logic spare);
		case (r.op)
			NFC_OP_READ: first_cmd = r.upper ? `NFC_CMD_READ1 :
				`NFC_CMD_READ0;
			NFC_OP_READ_SPARE: first_cmd = `NFC_CMD_READ_SPARE;
			NFC_OP_PROG: first_cmd = `NFC_CMD_SERIAL_IN;
			NFC_OP_PROG_SPARE: first_cmd = spare ? `NFC_CMD_SERIAL_IN :
				`NFC_CMD_READ_SPARE;
			NFC_OP_ERASE: first_cmd = `NFC_CMD_ERASE_SETUP;
			NFC_OP_STATUS: first_cmd = `NFC_CMD_STATUS;
			NFC_OP_RESUME: first_cmd = `NFC_CMD_READ0;
			default: first_cmd = `NFC_CMD_RESET;
		endcase
	endfunction
	function automatic logic is_prog(input nfc_op_t op);
		is_prog = (op == NFC_OP_PROG) || (op == NFC_OP_PROG_SPARE);
	endfunction
	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cur_nxt = cur_r;
		io_nxt = io_r;
		oe_nxt = oe_r;
		pin_nxt = pin_r;
		ph_nxt = ph_r + 2'd1;
		cnt_nxt = cnt_r;
		acnt_nxt = acnt_r;
		rdat_nxt = rdat_r;
		rdv_nxt = rdv_r && !rd_ready;
		rsp_nxt = rsp_r;
		rspv_nxt = 1'b0;
		bad_nxt = bad_r;
		good_nxt = good_r;
		in_read_nxt = in_read_r;
		spare_nxt = spare_r;
		fifo_pop = 1'b0;
		pg_wr = 1'b0;
		seg_wr = 1'b0;
		pg_val = '0;
		seg_val = '0;
		req_ready = (st_r == ST_IDLE);
		pin_nxt.wp_n = 1'b1;
		if (mark_bad && !bad_r[mark_block]) begin
			bad_nxt[mark_block] = 1'b1;
			good_nxt = good_r - 11'd1;
		end
		case (st_r)
			ST_IDLE: begin
				ph_nxt = '0;
				pin_nxt.ce_n = 1'b1;
				oe_nxt = 1'b0;
				if (req_valid) begin
					cur_nxt = req;
					rsp_nxt = '0;
					// Refuse rather than corrupt: order, count, bad, busy.
					if ((req.op == NFC_OP_ERASE && bad_r[req.block]) ||
						(is_prog(req.op) && bad_r[req.block]) ||
						(is_prog(req.op) &&
						{1'b0, req.page} != next_page_r[req.block] &&
						!({1'b0, req.page} + 6'd1 == next_page_r[req.block] &&
						segs_r[req.block] != `NFC_SEGMENTS)) ||
						(!ready_busy_n && req.op != NFC_OP_STATUS &&
						req.op != NFC_OP_RESET)) begin
						rsp_nxt.refused = 1'b1;
						st_nxt = ST_DONE;
					end else begin
						st_nxt = ST_CMD;
						io_nxt = first_cmd(req, spare_r);
						pin_nxt.ce_n = 1'b0;
					end
				end
			end
			ST_CMD, ST_CMD2: begin
				pin_nxt.cle = 1'b1;
				oe_nxt = 1'b1;
				pin_nxt.we_n = (ph_r != 2'd0);
				if (ph_r == 2'd1) begin
					pin_nxt.we_n = 1'b1;
				end else if (ph_r == 2'd2) begin
					pin_nxt.cle = 1'b0;
					ph_nxt = '0;
					acnt_nxt = '0;
					cnt_nxt = '0;
					if (st_r == ST_CMD2) begin
						st_nxt = ST_WAIT;
						cnt_nxt = 10'(`NFC_BUSY_CYC);
					end else begin
						case (io_r)
							`NFC_CMD_READ0, `NFC_CMD_READ1: begin
								spare_nxt = 1'b0;
								st_nxt = (cur_r.op == NFC_OP_RESUME) ?
									ST_DATA_R : ST_ADDR;
								in_read_nxt = 1'b1;
							end
							`NFC_CMD_READ_SPARE: begin
								spare_nxt = 1'b1;
								if (cur_r.op == NFC_OP_PROG_SPARE) begin
									io_nxt = `NFC_CMD_SERIAL_IN;
									st_nxt = ST_CMD;
								end else begin
									st_nxt = ST_ADDR;
									in_read_nxt = 1'b1;
								end
							end
							`NFC_CMD_STATUS: begin
								st_nxt = ST_STAT_RD;
							end
							`NFC_CMD_RESET: begin
								st_nxt = ST_WAIT;
								in_read_nxt = 1'b0;
								cnt_nxt = 10'(`NFC_BUSY_CYC);
							end
							default: st_nxt = ST_ADDR;
						endcase
						in_read_nxt = in_read_nxt &&
							io_r != `NFC_CMD_SERIAL_IN;
					end
				end
			end
			ST_ADDR: begin
				pin_nxt.ale = 1'b1;
				oe_nxt = 1'b1;
				if (ph_r == 2'd0) begin
					pin_nxt.we_n = 1'b0;
					case (acnt_r)
						2'd0: io_nxt = cur_r.column;
						2'd1: io_nxt = {cur_r.block[2:0], cur_r.page};
						default: io_nxt = {1'b0, cur_r.block[9:3]};
					endcase
					if (cur_r.op == NFC_OP_ERASE) begin
						io_nxt = (acnt_r == 2'd0) ?
							{cur_r.block[2:0], cur_r.page} :
							{1'b0, cur_r.block[9:3]};
					end
				end else if (ph_r == 2'd1) begin
					pin_nxt.we_n = 1'b1;
				end else if (ph_r == 2'd2) begin
					ph_nxt = '0;
					acnt_nxt = acnt_r + 2'd1;
					// Three cycles only, two for erase; a fourth would be ignored anyway.
					if (acnt_r == 2'd2 || (cur_r.op == NFC_OP_ERASE &&
						acnt_r == 2'd1)) begin
						pin_nxt.ale = 1'b0;
						cnt_nxt = '0;
						case (cur_r.op)
							NFC_OP_ERASE: begin
								io_nxt = `NFC_CMD_ERASE_EXEC;
								st_nxt = ST_CMD2;
							end
							NFC_OP_PROG, NFC_OP_PROG_SPARE:
								st_nxt = ST_DATA_W;
							default: begin
								st_nxt = ST_WAIT;
								cnt_nxt = 10'(`NFC_BUSY_CYC);
							end
						endcase
					end
				end
			end
			ST_DATA_W: begin
				oe_nxt = 1'b1;
				if (ph_r == 2'd0) begin
					if (fifo_v) begin
						io_nxt = fifo_out;
						fifo_pop = 1'b1;
						pin_nxt.we_n = 1'b0;
					end else begin
						ph_nxt = '0;
					end
				end else if (ph_r == 2'd1) begin
					pin_nxt.we_n = 1'b1;
				end else if (ph_r == 2'd2) begin
					ph_nxt = '0;
					cnt_nxt = cnt_r + 10'd1;
					if (cnt_r + 10'd1 == (spare_r ? `NFC_SPARE_BYTES :
						`NFC_PAGE_BYTES - {2'b0, cur_r.column})) begin
						io_nxt = `NFC_CMD_PROG_EXEC;
						st_nxt = ST_CMD2;
					end
				end
			end
			ST_WAIT: begin
				oe_nxt = 1'b0;
				ph_nxt = '0;
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 10'd1;
				end else if (ready_busy_n) begin
					cnt_nxt = '0;
					if (is_prog(cur_r.op) || cur_r.op == NFC_OP_ERASE) begin
						io_nxt = `NFC_CMD_STATUS;
						st_nxt = ST_STAT_CMD;
					end else if (cur_r.op == NFC_OP_RESET) begin
						st_nxt = ST_DONE;
					end else begin
						st_nxt = ST_DATA_R;
					end
				end
			end
			ST_STAT_CMD: begin
				st_nxt = ST_CMD;
				ph_nxt = '0;
			end
			ST_STAT_RD, ST_DATA_R: begin
				oe_nxt = 1'b0;
				if (ph_r == 2'd0) begin
					pin_nxt.read_strobe_n = 1'b0;
					if (st_r == ST_DATA_R && (rdv_r && !rd_ready)) begin
						pin_nxt.read_strobe_n = 1'b1;
						ph_nxt = '0;
					end
				end else if (ph_r == 2'd1) begin
					pin_nxt.read_strobe_n = 1'b1;
					if (st_r == ST_STAT_RD) begin
						rsp_nxt.status = io_in;
						rsp_nxt.fail = io_in[`NFC_ST_FAIL] &&
							io_in[`NFC_ST_READY];
						rsp_nxt.ok = io_in[`NFC_ST_READY] &&
							!io_in[`NFC_ST_FAIL];
						st_nxt = ST_DONE;
					end else begin
						rdat_nxt = io_in;
						rdv_nxt = 1'b1;
					end
				end else if (ph_r == 2'd2) begin
					ph_nxt = '0;
					cnt_nxt = cnt_r + 10'd1;
					if (cnt_r + 10'd1 == (spare_r ? `NFC_SPARE_BYTES :
						`NFC_PAGE_BYTES - {2'b0, cur_r.column})) begin
						rsp_nxt.ok = 1'b1;
						st_nxt = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				rspv_nxt = 1'b1;
				st_nxt = ST_IDLE;
				pin_nxt.ce_n = 1'b1;
				if (is_prog(cur_r.op) && rsp_r.ok) begin
					pg_wr = 1'b1;
					pg_val = {1'b0, cur_r.page} + 6'd1;
					seg_wr = 1'b1;
					seg_val = ({1'b0, cur_r.page} + 6'd1 ==
						next_page_r[cur_r.block]) ?
						segs_r[cur_r.block] + 2'd1 : 2'd1;
				end
				if (cur_r.op == NFC_OP_ERASE && rsp_r.ok) begin
					pg_wr = 1'b1;
					seg_wr = 1'b1;
				end
				if ((is_prog(cur_r.op) || cur_r.op == NFC_OP_ERASE) &&
					rsp_r.fail && !bad_r[cur_r.block]) begin
					bad_nxt[cur_r.block] = 1'b1;
					good_nxt = good_nxt - 11'd1;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= ST_IDLE;
			cur_r <= '0;
			io_r <= '0;
			oe_r <= 1'b0;
			pin_r <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
				read_strobe_n: 1'b1, wp_n: 1'b0};
			ph_r <= '0;
			cnt_r <= '0;
			acnt_r <= '0;
			rdat_r <= '0;
			rdv_r <= 1'b0;
			rsp_r <= '0;
			rspv_r <= 1'b0;
			bad_r <= '0;
			good_r <= `NFC_BLOCKS;
			in_read_r <= 1'b0;
			spare_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cur_r <= cur_nxt;
			io_r <= io_nxt;
			oe_r <= oe_nxt;
			pin_r <= pin_nxt;
			ph_r <= ph_nxt;
			cnt_r <= cnt_nxt;
			acnt_r <= acnt_nxt;
			rdat_r <= rdat_nxt;
			rdv_r <= rdv_nxt;
			rsp_r <= rsp_nxt;
			rspv_r <= rspv_nxt;
			bad_r <= bad_nxt;
			good_r <= good_nxt;
			in_read_r <= in_read_nxt;
			spare_r <= spare_nxt;
		end
	end
	// Per-block tables cleared by a synchronous reset; an erase that passes its status check clears the entry.
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 1024; i++) begin
				next_page_r[i] <= '0;
				segs_r[i] <= '0;
			end
		end else begin
			if (pg_wr) begin
				next_page_r[cur_r.block] <= pg_val;
			end
			if (seg_wr) begin
				segs_r[cur_r.block] <= seg_val;
			end
		end
	end
	always_comb begin
		pins = pin_r;
		io_out = io_r;
		io_oe = oe_r;
		rd_data = rdat_r;
		rd_valid = rdv_r;
		rsp = rsp_r;
		rsp_valid = rspv_r;
		good_blocks = good_r;
		too_few_good = (good_r < `NFC_MIN_GOOD);
	end
	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	no_bad_erase_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_CMD && cur_r.op == NFC_OP_ERASE) |->
		!bad_r[cur_r.block]) else $error("erase sent to bad block");
	after_serial_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_CMD2 && is_prog(cur_r.op)) |->
		io_r == `NFC_CMD_PROG_EXEC) else $error("bad command after input");
	busy_cmd_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_IDLE && req_valid && !ready_busy_n &&
		req.op == NFC_OP_READ) |=> st_r == ST_DONE)
		else $error("command sent while busy");
	status_seq_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_WAIT && ready_busy_n && cnt_r == '0 &&
		cur_r.op == NFC_OP_ERASE) |=> st_r == ST_STAT_CMD ##1 st_r == ST_CMD)
		else $error("no status after erase");
	bad_mark_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_DONE && rsp_r.fail && cur_r.op == NFC_OP_ERASE) |=>
		bad_r[$past(cur_r.block)]) else $error("failed block kept");
	wait_busy_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_WAIT && !ready_busy_n && cnt_r == '0) |=>
		st_r == ST_WAIT) else $error("left wait while busy");
	good_min_a: assert property (@(posedge mclk) disable iff (rst)
		too_few_good == (good_blocks < 11'd1004))
		else $error("good block floor wrong");
	wp_high_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r != ST_IDLE) |-> pins.wp_n) else $error("protect asserted");
	prog_cover_c: cover property (@(posedge mclk) disable iff (rst)
		st_r == ST_DONE && is_prog(cur_r.op) && rsp_r.ok);
	erase_cover_c: cover property (@(posedge mclk) disable iff (rst)
		st_r == ST_DONE && cur_r.op == NFC_OP_ERASE);
	read_cover_c: cover property (@(posedge mclk) disable iff (rst)
		st_r == ST_DATA_R && rd_valid);
endmodule

// ### nfc_pkg.sv
// Purpose: Types for the NAND host sequencer.
// Assumes: Byte-wide device.
// Notes: Constants live in nfc_regs.svh.
package nfc_pkg;
	typedef enum logic [2:0] {
		NFC_OP_READ, NFC_OP_READ_SPARE, NFC_OP_PROG, NFC_OP_PROG_SPARE,
		NFC_OP_ERASE, NFC_OP_STATUS, NFC_OP_RESET, NFC_OP_RESUME
	} nfc_op_t;
	typedef struct packed {
		nfc_op_t op;
		logic [9:0] block;
		logic [4:0] page;
		logic [7:0] column;
		logic upper;
		logic [1:0] segment;
	} nfc_req_t;
	typedef struct packed {
		logic ok;
		logic fail;
		logic refused;
		logic [7:0] status;
	} nfc_rsp_t;
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic read_strobe_n;
		logic wp_n;
	} nfc_pins_t;
endpackage

// ### nfc_regs.svh
// Purpose: Constants for the small-page NAND host sequencer.
// Assumes: Byte-wide device, 20 MHz mclk.
// Notes: Command codes, geometry, status bits and strobe timing.
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
// ----------------------------------------------------------------------
// Commands
// ----------------------------------------------------------------------
`define NFC_CMD_READ0 8'h00
`define NFC_CMD_READ1 8'h01
`define NFC_CMD_READ_SPARE 8'h50
`define NFC_CMD_SERIAL_IN 8'h80
`define NFC_CMD_PROG_EXEC 8'h10
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_EXEC 8'hD0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_RESET 8'hFF
// ----------------------------------------------------------------------
// Geometry and status
// ----------------------------------------------------------------------
`define NFC_BLOCKS 11'd1024
`define NFC_MIN_GOOD 11'd1004
`define NFC_PAGES 6'd32
`define NFC_PAGE_BYTES 10'd528
`define NFC_HALF_BYTES 10'd256
`define NFC_SPARE_BYTES 10'd16
`define NFC_SEGMENTS 2'd3
`define NFC_ST_FAIL 0
`define NFC_ST_READY 6
`define NFC_ST_WP 7
`define NFC_ERASED 8'hFF
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define NFC_CLK_NS 50
`define NFC_STROBE_NS 50
`define NFC_STROBE_CYC \
	(((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS) < 1 ? 1 : \
	((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS))
`define NFC_BUSY_NS 100
`define NFC_BUSY_CYC ((`NFC_BUSY_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// ### tb_top.sv
// Purpose: Self-checking bench for the NAND host sequencer.
// Assumes: Device model answers on the pins; busy line pulled up here.
// Notes: A monitor gathers read bytes; the first byte of each read but the resume is judged.
`timescale 1ns/1ps
module tb_top;
	import nfc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic wr_valid = 1'b0;
	logic rd_ready = 1'b0;
	logic mark_bad = 1'b0;
	logic ext_busy = 1'b0;
	logic force_fail = 1'b0;
	logic [9:0] mark_block = 10'h000;
	logic [7:0] wr_data = 8'h00;
	nfc_req_t req = '0;
	nfc_rsp_t rsp;
	nfc_pins_t pins;
	logic req_ready, rsp_valid, wr_ready, rd_valid, too_few_good, io_oe, rb_low;
	logic [7:0] rd_data, io_in, io_out;
	logic [10:0] good_blocks;
	logic [7:0] rq [$];
	int errors = 0;
	int samples_checked = 0;
	// A second device on the wired line may also hold it low.
	wire ready_busy_n = !(rb_low || ext_busy);
	always #25 mclk = ~mclk;
	nfc_host u_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp(rsp), .rsp_valid(rsp_valid),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.mark_bad(mark_bad), .mark_block(mark_block),
		.good_blocks(good_blocks), .too_few_good(too_few_good), .pins(pins),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe),
		.ready_busy_n(ready_busy_n));
	nfc_dev_model u_dev (.mclk(mclk), .pins(pins), .io_out(io_out),
		.force_fail(force_fail), .io_in(io_in), .rb_low(rb_low));
	// The reader stalls every other cycle to exercise the hold.
	always @(posedge mclk) begin
		rd_ready <= ~rd_ready;
		if (rd_valid && rd_ready)
			rq.push_back(rd_data);
	end
	task automatic report_and_stop();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic hang(int n, int lim);
		if (n >= lim) begin
			errors++;
			report_and_stop();
		end
	endtask
	task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_req(nfc_op_t op, int b, int p, int c, bit up);
		int n;
		rq.delete();
		req <= {op, b[9:0], p[4:0], c[7:0], up, 2'h0};
		req_valid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (req_ready)
				break;
		end
		hang(n, 50);
		req_valid <= 1'b0;
		for (n = 0; n < 9000; n++) begin
			@(posedge mclk);
			if (rsp_valid)
				break;
		end
		hang(n, 9000);
	endtask
	task automatic feed(int from, int to, bit sp);
		int n;
		for (int i = from; i < to; i++) begin
			wr_data <= sp ? 8'h0F : (i < 256 ? 8'hA5 : (i < 512 ? 8'h3C : 8'h77));
			wr_valid <= 1'b1;
			for (n = 0; n < 4000; n++) begin
				@(posedge mclk);
				if (wr_ready)
					break;
			end
			hang(n, 4000);
		end
		wr_valid <= 1'b0;
	endtask
	task automatic mark(int b);
		mark_block <= b[9:0];
		mark_bad <= 1'b1;
		@(posedge mclk);
		mark_bad <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic scn_fill_prog();
		do_req(NFC_OP_ERASE, 2, 0, 0, 0);
		chk("erase ok", 11'h001, rsp.ok);
		feed(0, 16, 0);
		@(posedge mclk);
		chk("fifo full", 11'h000, wr_ready);
		fork
			do_req(NFC_OP_PROG, 2, 0, 0, 0);
			feed(16, 528, 0);
		join
		chk("prog status", 11'h0C0, rsp.status);
	endtask
	task automatic scn_pointer();
		do_req(NFC_OP_READ, 2, 0, 0, 0);
		chk("first half", 11'h0A5, rq[0]);
		do_req(NFC_OP_READ, 2, 0, 0, 1);
		chk("second half", 11'h03C, rq[0]);
		do_req(NFC_OP_READ_SPARE, 2, 0, 0, 0);
		chk("spare area", 11'h077, rq[0]);
		do_req(NFC_OP_READ, 2, 0, 0, 0);
		chk("pointer back", 11'h0A5, rq[0]);
		do_req(NFC_OP_STATUS, 2, 0, 0, 0);
		chk("status byte", 11'h0C0, rsp.status);
		do_req(NFC_OP_RESUME, 2, 0, 0, 0);
		chk("resume ok", 11'h001, rsp.ok);
	endtask
	task automatic scn_partial();
		repeat (2) begin
			fork
				do_req(NFC_OP_PROG_SPARE, 2, 0, 0, 0);
				feed(0, 16, 1);
			join
			chk("spare prog", 11'h001, rsp.ok);
		end
		do_req(NFC_OP_READ_SPARE, 2, 0, 0, 0);
		chk("spare merged", 11'h007, rq[0]);
		do_req(NFC_OP_PROG_SPARE, 2, 0, 0, 0);
		chk("fourth partial", 11'h001, rsp.refused);
		do_req(NFC_OP_PROG, 2, 2, 0, 0);
		chk("page skip", 11'h001, rsp.refused);
	endtask
	task automatic scn_busy_bad();
		ext_busy <= 1'b1;
		do_req(NFC_OP_READ, 2, 0, 0, 0);
		chk("read while busy", 11'h001, rsp.refused);
		do_req(NFC_OP_STATUS, 2, 0, 0, 0);
		chk("status while busy", 11'h000, rsp.refused);
		ext_busy <= 1'b0;
		do_req(NFC_OP_RESET, 2, 0, 0, 0);
		chk("reset taken", 11'h000, rsp.refused);
		mark(5);
		chk("good count", 11'd1023, good_blocks);
		do_req(NFC_OP_ERASE, 5, 0, 0, 0);
		chk("erase bad", 11'h001, rsp.refused);
		force_fail <= 1'b1;
		do_req(NFC_OP_ERASE, 7, 0, 0, 0);
		force_fail <= 1'b0;
		chk("fail status", 11'h0C1, rsp.status);
		chk("fail flag", 11'h001, rsp.fail);
		do_req(NFC_OP_ERASE, 7, 0, 0, 0);
		chk("failed retired", 11'h001, rsp.refused);
		for (int b = 100; b < 118; b++)
			mark(b);
		chk("at minimum", 11'h000, too_few_good);
		mark(118);
		chk("below minimum", 11'h001, too_few_good);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		scn_fill_prog();
		scn_pointer();
		scn_partial();
		scn_busy_bad();
		report_and_stop();
	end
endmodule
